// ===== rtl/pil_latch.sv
// programming input latch of a programmable dc source
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module pil_latch (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst,
  input  wire logic [pil_pkg::MAG_W-1:0] i_mag_n,
  input  wire logic                  i_span_n,
  input  wire logic                  i_sign_n,
  input  wire logic                  i_standby_n,
  input  wire logic                  i_strobe_n,
  input  wire logic                  i_trim_weight,
  output logic [pil_pkg::LEVEL_W-1:0] o_level_mv,
  output logic                       o_negative,
  output logic                       o_span_high,
  output logic                       o_standby,
  output logic                       o_code_invalid,
  output logic                       o_not_ready_n
);
  import pil_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic               strobe_n_d;
    logic [MAG_W-1:0]   code;
    logic               neg;
    logic               span;
    logic               stby;
    logic [LEVEL_W-1:0] level;
    logic               invalid;
    pil_state_t         fsm;
    // read only by the checks below; synthesis trims it
    logic [CNT_W-1:0]   chk_wait;
  } pil_lat_t;

  pil_lat_t st_r;
  pil_lat_t st_nxt;
  logic     load;
  logic     settle_done;

  // falling edge of the strobe pin, i.e. its asserted edge
  assign load = st_r.strobe_n_d & ~i_strobe_n;

  function automatic logic [MAG_W-1:0] mag_of(
    input logic [MAG_W-1:0] code,
    input logic             neg
  );
    mag_of = neg ? MAG_W'(~code + MAG_W'(1)) : code;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [MAG_W-1:0]   mag;
  logic [MAG_W+7:0]   trim_prod;
  logic [LEVEL_W-1:0] base;

  always_comb begin
    st_nxt            = st_r;
    st_nxt.strobe_n_d = i_strobe_n;
    if (load) begin
      st_nxt.code = ~i_mag_n;
      st_nxt.neg  = ~i_sign_n;
      st_nxt.span = ~i_span_n;
      st_nxt.stby = ~i_standby_n;
    end
    mag       = mag_of(st_r.code, st_r.neg);
    trim_prod = (MAG_W+8)'(mag) * (MAG_W+8)'(TRIM_MUL);
    // trim loses a fraction of a count; accepted, it is a strap option
    base      = i_trim_weight ?
                LEVEL_W'(trim_prod >> TRIM_SHIFT) : LEVEL_W'(mag);
    // a negative zero code has no valid magnitude
    st_nxt.invalid = st_r.neg && (st_r.code == '0);
    if (st_r.stby || st_nxt.invalid) begin
      st_nxt.level = '0;
    end else if (st_r.span) begin
      st_nxt.level = LEVEL_W'(base << SPAN_HI_SHIFT);
    end else begin
      st_nxt.level = base;
    end
    // settling cycles since the latest load, held once ready, saturating; feeds the settle checks
    if (load) begin
      st_nxt.chk_wait = '0;
    end else if (st_r.fsm == PIL_SETTLE && st_r.chk_wait != '1) begin
      st_nxt.chk_wait = st_r.chk_wait + CNT_W'(1);
    end
    case (st_r.fsm)
      PIL_READY: begin
        if (load) begin
          st_nxt.fsm = PIL_SETTLE;
        end
      end
      PIL_SETTLE: begin
        if (settle_done && !load) begin
          st_nxt.fsm = PIL_READY;
        end
      end
      default: st_nxt.fsm = PIL_READY;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r            <= '0;
      st_r.strobe_n_d <= 1'b1;
      st_r.code       <= MAG_RST;
      st_r.level      <= LVL_RST;
      st_r.fsm        <= PIL_READY;
    end else begin
      st_r <= st_nxt;
    end
  end

  pil_settle_timer u_settle (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_start   (load),
    .o_done    (settle_done)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_level_mv     = st_r.level;
  assign o_negative     = st_r.neg;
  assign o_span_high    = st_r.span;
  assign o_standby      = st_r.stby;
  assign o_code_invalid = st_r.invalid;
  // pin is negative logic: low means not ready
  assign o_not_ready_n  = ~(st_r.fsm == PIL_SETTLE);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  AST_STANDBY_ZERO: assert property (
    st_r.stby |=> o_level_mv == '0)
    else $error("level not zero in standby");
  AST_SPAN_CAPTURE: assert property (
    load |=> o_span_high == !$past(i_span_n))
    else $error("span not captured");
  AST_CODE_CAPTURE: assert property (
    load |=> st_r.code == ~$past(i_mag_n))
    else $error("magnitude not captured");
  AST_LOW_SPAN_1MV: assert property (
    load && i_span_n && i_sign_n && i_standby_n && !i_trim_weight
    ##1 !i_trim_weight |=> o_level_mv == {2'b00, ~$past(i_mag_n, 2)})
    else $error("low span scale wrong");
  AST_HIGH_SPAN_X4: assert property (
    load && !i_span_n && i_sign_n && i_standby_n && !i_trim_weight
    ##1 !i_trim_weight |=>
    o_level_mv == LEVEL_W'({2'b00, ~$past(i_mag_n, 2)} << 2))
    else $error("high span scale wrong");
  AST_TRIM_MSB: assert property (
    i_trim_weight && !st_r.stby && !st_r.neg && !st_r.span &&
    st_r.code == 14'h2000 |=> o_level_mv == 16'h1f40)
    else $error("trim msb not 8 V");
  AST_SIGN_CAPTURE: assert property (
    load |=> o_negative == !$past(i_sign_n))
    else $error("sign not captured");
  AST_HOLD: assert property (
    !load |=> $stable(st_r.code) && $stable(o_negative) &&
    $stable(o_span_high))
    else $error("latch changed without strobe");
  AST_NOT_READY: assert property (
    load |=> !o_not_ready_n)
    else $error("not-ready missing after load");
  AST_SETTLE_BOUND: assert property (
    !o_not_ready_n |-> st_r.chk_wait <= CNT_W'(SETTLE_CYC))
    else $error("settling too long");
  AST_SETTLE_FULL: assert property (
    $rose(o_not_ready_n) |-> st_r.chk_wait == CNT_W'(SETTLE_CYC + 1))
    else $error("ready before settling time");
  AST_READY_IDLE: assert property (
    o_not_ready_n && !load |=> o_not_ready_n)
    else $error("not-ready without load");
  AST_STANDBY_CAPTURE: assert property (
    load |=> o_standby == !$past(i_standby_n))
    else $error("standby not captured");
  AST_HOLD_STANDBY: assert property (
    !load |=> $stable(o_standby))
    else $error("standby changed without strobe");
  AST_NEG_INVALID: assert property (
    st_r.neg && st_r.code == '0 |=> o_code_invalid && o_level_mv == '0)
    else $error("negative zero code not flagged");
  AST_NEG_TWOS: assert property (
    st_r.neg && !st_r.stby && !st_r.span && !i_trim_weight &&
    st_r.code != '0 |=> o_level_mv + {2'b00, $past(st_r.code)} == 16'h4000)
    else $error("negative magnitude wrong");
  AST_TRIM_MSB_HIGH: assert property (
    i_trim_weight && !st_r.stby && !st_r.neg && st_r.span &&
    st_r.code == 14'h2000 |=> o_level_mv == 16'h7d00)
    else $error("trim msb not 32 V");

  COV_LOAD:      cover property (load);
  COV_READY:     cover property ($rose(o_not_ready_n));
  COV_STANDBY:   cover property (load && !i_standby_n);
  COV_INVALID:   cover property (o_code_invalid);
  COV_HIGH_SPAN: cover property (load && !i_span_n);
endmodule // pil_latch
`default_nettype wire

// ===== rtl/pil_pkg.sv
// constants shared by the programming input latch
package pil_pkg;
  localparam int unsigned MAG_W          = 14;
  localparam int unsigned LEVEL_W        = 16;
  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned SETTLE_TIME_US = 50;
  localparam int unsigned SETTLE_CYC     = SETTLE_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W          = 12;
  localparam int unsigned SPAN_HI_SHIFT  = 2;
  localparam int unsigned TRIM_MUL       = 125;
  localparam int unsigned TRIM_SHIFT     = 7;
  localparam logic [MAG_W-1:0] MAG_RST   = 14'h0000;
  localparam logic [LEVEL_W-1:0] LVL_RST = 16'h0000;

  typedef enum logic [1:0] {
    PIL_READY  = 2'b00,
    PIL_SETTLE = 2'b01
  } pil_state_t;
endpackage : pil_pkg

// ===== rtl/pil_settle_timer.sv
// one-shot settling timer, counts a fixed number of clock cycles
`timescale 1ns/10ps
`default_nettype none
module pil_settle_timer (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_start,
  output logic      o_done
);
  import pil_pkg::*;

  typedef struct packed {
    logic             run;
    logic [CNT_W-1:0] cnt;
    logic             done;
  } pil_tmr_t;

  pil_tmr_t tmr_r;
  pil_tmr_t tmr_nxt;

  always_comb begin
    tmr_nxt      = tmr_r;
    tmr_nxt.done = 1'b0;
    if (i_start) begin
      // a fresh load restarts the wait
      tmr_nxt.run = 1'b1;
      tmr_nxt.cnt = CNT_W'(SETTLE_CYC - 1);
    end else if (tmr_r.run) begin
      if (tmr_r.cnt == '0) begin
        tmr_nxt.run  = 1'b0;
        tmr_nxt.done = 1'b1;
      end else begin
        tmr_nxt.cnt = tmr_r.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tmr_r <= '0;
    end else begin
      tmr_r <= tmr_nxt;
    end
  end

  assign o_done = tmr_r.done;
endmodule // pil_settle_timer
`default_nettype wire

// ===== sim/pil_prog_model.sv
// model of the external programming logic at the pins
`timescale 1ns/10ps
`default_nettype none
module pil_prog_model (
  input  wire logic                  i_ref_clk,
  output logic [pil_pkg::MAG_W-1:0]  o_mag_n,
  output logic                       o_span_n,
  output logic                       o_sign_n,
  output logic                       o_standby_n,
  output logic                       o_strobe_n
);
  import pil_pkg::*;
  // open contacts float high and read as zero
  initial begin
    o_mag_n = '1;
    {o_span_n, o_sign_n, o_standby_n, o_strobe_n} = 4'hf;
  end
  // negatives go out as twos complement, pins inverted
  task automatic send(input logic [13:0] v, input logic span, neg, sb,
                      input logic stb);
    @(posedge i_ref_clk) #1;
    o_mag_n = neg ? ~(~v + 14'h0001) : ~v;
    o_span_n = ~span;
    o_sign_n = ~neg;
    o_standby_n = ~sb;
    o_strobe_n = ~stb;
    @(posedge i_ref_clk) #1;
    o_strobe_n = 1'b1;
  endtask
endmodule // pil_prog_model
`default_nettype wire

// ===== sim/programming_input_latch_test.sv
// self-checking bench of the programming input latch
`timescale 1ns/10ps
`default_nettype none
module programming_input_latch_test;
  import pil_pkg::*;
  logic clk, rst, trim, span_n, sign_n, sb_n, stb_n;
  logic neg, spn, sb, inv, rdy_n;
  logic [MAG_W-1:0]   mag_n;
  logic [LEVEL_W-1:0] lvl;
  int mismatches, n_checks, cyc;
  pil_prog_model PM (.i_ref_clk(clk), .o_mag_n(mag_n), .o_span_n(span_n),
    .o_sign_n(sign_n), .o_standby_n(sb_n), .o_strobe_n(stb_n));
  pil_latch DUT (.i_ref_clk(clk), .i_rst(rst), .i_mag_n(mag_n),
    .i_span_n(span_n), .i_sign_n(sign_n), .i_standby_n(sb_n),
    .i_strobe_n(stb_n), .i_trim_weight(trim), .o_level_mv(lvl),
    .o_negative(neg), .o_span_high(spn), .o_standby(sb),
    .o_code_invalid(inv), .o_not_ready_n(rdy_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ------------------------------------------------------------
  // checks and closing
  // ------------------------------------------------------------
  task automatic chk_lvl(input logic [15:0] e);
    n_checks++;
    if (lvl !== e) begin
      mismatches++;
      $display("[ERR] %0t level %h exp %h", $time, lvl, e);
    end
  endtask
  task automatic chk_flag(input logic g, e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t flag %b exp %b", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // load, then wait until the level register has landed
  task automatic ld(input logic [13:0] v, input logic s, n, b, t);
    PM.send(v, s, n, b, t);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_spans();
    logic [13:0] v[3] = '{14'h0001, 14'h2000, 14'h3fff};
    for (int s = 0; s < 2; s++) begin
      foreach (v[i]) begin
        ld(v[i], s[0], 1'b0, 1'b0, 1'b1);
        chk_lvl(s[0] ? {v[i], 2'b00} : {2'b00, v[i]});
        chk_flag(spn, s[0]);
        chk_flag(neg, 1'b0);
      end
    end
  endtask
  task automatic t_neg();
    logic [13:0] v[4] = '{14'h0001, 14'h2000, 14'h3fff, 14'h0000};
    foreach (v[i]) begin
      ld(v[i], 1'b0, 1'b1, 1'b0, 1'b1);
      chk_lvl({2'b00, v[i]});
      chk_flag(neg, 1'b1);
      chk_flag(inv, v[i] == 14'h0000);
    end
  endtask
  task automatic t_trim();
    trim = 1'b1;
    ld(14'h2000, 1'b0, 1'b0, 1'b0, 1'b1);
    chk_lvl(16'h1f40);
    ld(14'h2000, 1'b1, 1'b0, 1'b0, 1'b1);
    chk_lvl(16'h7d00);
    trim = 1'b0;
  endtask
  task automatic t_stby_hold();
    ld(14'h0100, 1'b0, 1'b0, 1'b1, 1'b1);
    chk_flag(sb, 1'b1);
    chk_lvl(16'h0000);
    ld(14'h0100, 1'b0, 1'b0, 1'b0, 1'b1);
    chk_lvl(16'h0100);
    ld(14'h0555, 1'b1, 1'b1, 1'b1, 1'b0);
    repeat (3) @(posedge clk);
    chk_lvl(16'h0100);
    chk_flag(spn, 1'b0);
  endtask
  task automatic t_settle();
    ld(14'h0042, 1'b0, 1'b0, 1'b0, 1'b1);
    chk_flag(rdy_n, 1'b0);
    repeat (SETTLE_CYC - 2) @(posedge clk);
    #1;
    chk_flag(rdy_n, 1'b0);
    @(posedge clk);
    #1;
    chk_flag(rdy_n, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk_flag(rdy_n, 1'b1);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    rst = 1'b1;
    trim = 1'b0;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    t_spans();
    t_neg();
    t_trim();
    t_stby_hold();
    t_settle();
    give_verdict();
  end
endmodule // programming_input_latch_test
`default_nettype wire
